// ==== design/sss_sequencer.sv ====
// Top of the system sleep-state sequencer: control writes, sleep hold,
// wake handling, resource gating and the wake-result words.
// Assumes wake, fault and supply pins are asynchronous and are synchronised here.
`timescale 1ns/1ns
module sss_sequencer (
	input  wire logic                        sys_clk_i,
	input  wire logic                        sys_rst_i,
	input  wire logic                        primary_wr_i,
	input  wire logic [sss_pkg::TYPE_W-1:0]  primary_type_i,
	input  wire logic                        secondary_wr_i,
	input  wire logic [sss_pkg::TYPE_W-1:0]  secondary_type_i,
	input  wire logic                        sleep_enable_bit_i,
	input  wire logic                        hibernate_req_i,
	input  wire logic                        wake_clear_i,
	input  wire logic [sss_pkg::NUM_DEV-1:0] wake_event_i,
	input  wire logic [sss_pkg::NUM_DEV-1:0] wake_enable_i,
	input  wire logic                        power_fail_i,
	input  wire logic                        thermal_fail_i,
	input  wire logic [sss_pkg::STATE_W-1:0] supply_state_i,
	input  wire logic                        track_enable_i,
	input  wire sss_pkg::sss_level_t         res_level_i,
	input  wire sss_pkg::sss_need_t          dev_need_i,
	input  wire sss_pkg::sss_dstate_t        dev_req_dstate_i,
	output sss_pkg::sss_ctl_s                ctl_o,
	output logic [sss_pkg::NUM_RES-1:0]      res_on_o,
	output sss_pkg::sss_dstate_t             dev_dstate_o,
	output logic                             boot_start_o,
	output logic                             cold_boot_o,
	output logic [sss_pkg::STATE_W-1:0]      ended_state_o,
	output logic                             wake_status_flag_o,
	output logic [sss_pkg::WORD_W-1:0]       wake_result_status_o,
	output logic [sss_pkg::WORD_W-1:0]       supply_state_result_o
);
	import sss_pkg::*;

	// Set when the platform offers the firmware hibernate path to S4.
	parameter bit HIBERNATE_SUPPORTED = 1'b1;

	// Maps a sleep type code to a numeric state; unknown codes mean stay awake.
	function automatic logic [STATE_W-1:0] type_to_state(input logic [TYPE_W-1:0] t);
		case (t)
			TYP_S2:  type_to_state = ST_S2;
			TYP_S3:  type_to_state = ST_S3;
			TYP_S4:  type_to_state = ST_S4;
			TYP_S5:  type_to_state = ST_S5;
			default: type_to_state = ST_S0;
		endcase
	endfunction

	// ==========================================================================
	// Input synchronisers
	localparam int unsigned SYNC_W = NUM_DEV + 2 + STATE_W;
	logic [SYNC_W-1:0] meta_q;
	logic [SYNC_W-1:0] sync_q;
	logic [SYNC_W-1:0] sync_d;
	logic [NUM_DEV-1:0] wake_s;
	logic               pfail_s;
	logic               tfail_s;
	logic [STATE_W-1:0] supply_s;

	always_comb begin
		sync_d = meta_q;
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= {wake_event_i, power_fail_i, thermal_fail_i, supply_state_i};
			sync_q <= sync_d;
		end
	end

	assign {wake_s, pfail_s, tfail_s, supply_s} = sync_q;

	// ==========================================================================
	// Sequencer
	sss_seq_e           seq_q;
	sss_seq_e           seq_d;
	logic [TYPE_W-1:0]  ptype_q;
	logic [TYPE_W-1:0]  ptype_d;
	logic               ptype_ok_q;
	logic               ptype_ok_d;
	logic [STATE_W-1:0] tgt_q;
	logic [STATE_W-1:0] tgt_d;
	logic [STATE_W-1:0] ended_q;
	logic [STATE_W-1:0] ended_d;
	logic               flag_q;
	logic               flag_d;
	logic               boot_q;
	logic               boot_d;
	logic               cold_q;
	logic               cold_d;
	logic [WORD_W-1:0]  sts_q;
	logic [WORD_W-1:0]  sts_d;
	logic [WORD_W-1:0]  pss_q;
	logic [WORD_W-1:0]  pss_d;
	logic               wake_hit;
	logic [STATE_W-1:0] req_state;

	assign wake_hit  = |(wake_s & wake_enable_i);
	assign req_state = type_to_state(secondary_type_i);

	always_comb begin
		seq_d      = seq_q;
		ptype_d    = ptype_q;
		ptype_ok_d = ptype_ok_q;
		tgt_d      = tgt_q;
		ended_d    = ended_q;
		boot_d     = 1'b0;
		cold_d     = cold_q;
		sts_d      = sts_q;
		pss_d      = pss_q;
		flag_d     = flag_q & ~wake_clear_i;
		case (seq_q)
			SSS_RUN: begin
				if (primary_wr_i) begin
					ptype_d    = primary_type_i;
					ptype_ok_d = 1'b1;
				end
				if (secondary_wr_i && sleep_enable_bit_i && ptype_ok_q &&
				    secondary_type_i == ptype_q && req_state != ST_S0) begin
					tgt_d      = req_state;
					ptype_ok_d = 1'b0;
					sts_d      = WORD_ZERO;
					seq_d      = SSS_SLEEP;
				end
				else if (HIBERNATE_SUPPORTED && hibernate_req_i) begin
					tgt_d = ST_S4;
					sts_d = WORD_ZERO;
					seq_d = SSS_SLEEP;
				end
			end
			SSS_SLEEP: begin
				pss_d = track_enable_i ? {{(WORD_W-STATE_W){1'b0}}, supply_s} : WORD_ZERO;
				if (wake_hit) begin
					if (pfail_s || tfail_s) begin
						if (track_enable_i) begin
							sts_d[STS_POWER_BIT]   = sts_q[STS_POWER_BIT] | pfail_s;
							sts_d[STS_THERMAL_BIT] = sts_q[STS_THERMAL_BIT] | tfail_s;
						end
					end else begin
						seq_d = SSS_BOOT;
					end
				end
			end
			SSS_BOOT: begin
				boot_d  = 1'b1;
				// S5 wake is a cold boot
				cold_d  = (tgt_q == ST_S5);
				ended_d = tgt_q;
				flag_d  = 1'b1;
				tgt_d   = ST_S0;
				seq_d   = SSS_RUN;
			end
			default: begin
				seq_d = SSS_RUN;
				tgt_d = ST_S0;
			end
		endcase
		if (!track_enable_i) begin
			sts_d = WORD_ZERO;
			pss_d = WORD_ZERO;
		end
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			seq_q      <= SSS_RUN;
			ptype_q    <= TYP_S0;
			ptype_ok_q <= 1'b0;
			tgt_q      <= ST_S0;
			ended_q    <= ST_S0;
			flag_q     <= 1'b0;
			boot_q     <= 1'b0;
			cold_q     <= 1'b0;
			sts_q      <= WORD_ZERO;
			pss_q      <= WORD_ZERO;
		end else begin
			seq_q      <= seq_d;
			ptype_q    <= ptype_d;
			ptype_ok_q <= ptype_ok_d;
			tgt_q      <= tgt_d;
			ended_q    <= ended_d;
			flag_q     <= flag_d;
			boot_q     <= boot_d;
			cold_q     <= cold_d;
			sts_q      <= sts_d;
			pss_q      <= pss_d;
		end
	end

	// ==========================================================================
	// Power resources, processor and memory controls
	// A resource with reference level L powers down in any state deeper than L,
	// so the comparison alone covers S2, S3, S4 and S5.
	sss_ctl_s           ctl_q;
	sss_ctl_s           ctl_d;
	logic [NUM_RES-1:0] res_q;
	logic [NUM_RES-1:0] res_d;
	sss_dstate_t        dst_q;
	sss_dstate_t        dst_d;

	always_comb begin
		for (int r = 0; r < NUM_RES; r++) begin
			res_d[r] = (tgt_q == ST_S0) || (res_level_i[r] >= tgt_q);
		end
		ctl_d.cpu_run = (tgt_q == ST_S0);
		ctl_d.cpu_ctx_keep = (tgt_q == ST_S0);
		ctl_d.dram_retain  = (tgt_q == ST_S0) || (tgt_q == ST_S2) || (tgt_q == ST_S3);
	end

	// Gating uses the registered resource view, so devices follow one cycle later.
	sss_dev_gate u_dev_gate (
		.state_i      (tgt_q),
		.res_on_i     (res_q),
		.need_i       (dev_need_i),
		.req_dstate_i (dev_req_dstate_i),
		.dstate_o     (dst_d)
	);

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctl_q <= '{cpu_run: 1'b1, cpu_ctx_keep: 1'b1, dram_retain: 1'b1};
			res_q <= '1;
			dst_q <= '0;
		end else begin
			ctl_q <= ctl_d;
			res_q <= res_d;
			dst_q <= dst_d;
		end
	end

	assign ctl_o                 = ctl_q;
	assign res_on_o              = res_q;
	assign dev_dstate_o          = dst_q;
	assign boot_start_o          = boot_q;
	assign cold_boot_o           = cold_q;
	assign ended_state_o         = ended_q;
	assign wake_status_flag_o    = flag_q;
	assign wake_result_status_o  = sts_q;
	assign supply_state_result_o = pss_q;

endmodule

// ==== design/sss_pkg.sv ====
// Constants, types and encodings shared by the sleep-state sequencer files.
// Assumes a single always-on clock and an active-high asynchronous reset.
// ==========================================================================
package sss_pkg;

	localparam int unsigned NUM_DEV   = 4;
	localparam int unsigned NUM_RES   = 4;
	localparam int unsigned TYPE_W    = 3;
	localparam int unsigned STATE_W   = 3;
	localparam int unsigned WORD_W    = 32;

	// Sleep type codes as seen in the sleep_type_field; S5 differs from S4.
	localparam logic [TYPE_W-1:0] TYP_S0 = 3'h0;
	localparam logic [TYPE_W-1:0] TYP_S2 = 3'h2;
	localparam logic [TYPE_W-1:0] TYP_S3 = 3'h3;
	localparam logic [TYPE_W-1:0] TYP_S4 = 3'h4;
	localparam logic [TYPE_W-1:0] TYP_S5 = 3'h5;

	// Numeric system states.
	localparam logic [STATE_W-1:0] ST_S0 = 3'h0;
	localparam logic [STATE_W-1:0] ST_S2 = 3'h2;
	localparam logic [STATE_W-1:0] ST_S3 = 3'h3;
	localparam logic [STATE_W-1:0] ST_S4 = 3'h4;
	localparam logic [STATE_W-1:0] ST_S5 = 3'h5;

	localparam logic [1:0] DSTATE_D3 = 2'h3;

	localparam int unsigned STS_POWER_BIT   = 0;
	localparam int unsigned STS_THERMAL_BIT = 1;
	localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		SSS_RUN,
		SSS_SLEEP,
		SSS_BOOT
	} sss_seq_e;

	// Processor and memory controls driven while asleep or running.
	typedef struct packed {
		logic cpu_run;
		logic cpu_ctx_keep;
		logic dram_retain;
	} sss_ctl_s;

	typedef logic [NUM_DEV-1:0][1:0]         sss_dstate_t;
	typedef logic [NUM_DEV-1:0][NUM_RES-1:0] sss_need_t;
	typedef logic [NUM_RES-1:0][STATE_W-1:0] sss_level_t;

endpackage

// ==== design/sss_dev_gate.sv ====
// Device-state forcing for the sleep-state sequencer.
// Assumes inputs are already in the system clock domain; purely combinational.
`timescale 1ns/1ns
module sss_dev_gate (
	input  wire logic [sss_pkg::STATE_W-1:0] state_i,
	input  wire logic [sss_pkg::NUM_RES-1:0] res_on_i,
	input  wire sss_pkg::sss_need_t          need_i,
	input  wire sss_pkg::sss_dstate_t        req_dstate_i,
	output sss_pkg::sss_dstate_t             dstate_o
);
	import sss_pkg::*;

	// ==========================================================================
	// Device state selection
	always_comb begin
		for (int d = 0; d < NUM_DEV; d++) begin
			dstate_o[d] = req_dstate_i[d];
			if (state_i == ST_S4 || state_i == ST_S5) begin
				dstate_o[d] = DSTATE_D3;
			end
			else if (state_i == ST_S2 || state_i == ST_S3) begin
				if ((need_i[d] & ~res_on_i) != '0) begin
					dstate_o[d] = DSTATE_D3;
				end
			end
		end
	end

endmodule

// ==== tb/sss_sequencer_assertions.sv ====
// Concurrent checks on the sleep-state sequencer top ports.
// Assumes one system clock and an active-high asynchronous reset.
`timescale 1ns/1ns
module sss_chk (
	input wire logic                          sys_clk_i,
	input wire logic                          sys_rst_i,
	input wire logic                          track_enable_i,
	input wire sss_pkg::sss_ctl_s             ctl_o,
	input wire logic [sss_pkg::NUM_RES-1:0]   res_on_o,
	input wire sss_pkg::sss_dstate_t          dev_dstate_o,
	input wire logic                          boot_start_o,
	input wire logic                          cold_boot_o,
	input wire logic [sss_pkg::STATE_W-1:0]   ended_state_o,
	input wire logic                          wake_status_flag_o,
	input wire logic [sss_pkg::WORD_W-1:0]    wake_result_status_o,
	input wire logic [sss_pkg::WORD_W-1:0]    supply_state_result_o
);
	import sss_pkg::*;
	// ==========================================================
	// Wake, sleep and result-word relations
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence back_to_run_s;
		##1 (!boot_start_o && ctl_o == 3'h7 && &res_on_o);
	endsequence
	boot_back_a: assert property (boot_start_o |-> back_to_run_s)
		else $error("boot pulse not followed by run state");
	boot_flag_a: assert property (boot_start_o |-> wake_status_flag_o)
		else $error("wake flag missing at boot pulse");
	ended_num_a: assert property (boot_start_o |-> ended_state_o inside {[3'h2:3'h5]})
		else $error("ended state out of range");
	cold_boot_a: assert property (boot_start_o |-> cold_boot_o == (ended_state_o == ST_S5))
		else $error("cold boot marker wrong");
	asleep_ctx_a: assert property (!ctl_o.cpu_run |-> !ctl_o.cpu_ctx_keep)
		else $error("context kept while asleep");
	deep_d3_a: assert property (!ctl_o.dram_retain && $past(!ctl_o.dram_retain) |-> dev_dstate_o == '1)
		else $error("device not in D3 during deep sleep");
	rsvd_bits_a: assert property (wake_result_status_o[31:2] == '0)
		else $error("reserved status bits set");
	supply_word_a: assert property (supply_state_result_o[31:3] == '0)
		else $error("supply word upper bits set");
	track_off_a: assert property (!track_enable_i && $past(!track_enable_i)
		|-> wake_result_status_o == '0 && supply_state_result_o == '0)
		else $error("result words not zero without tracking");
endmodule
bind sss_sequencer sss_chk u_chk (
	.sys_clk_i             (sys_clk_i),
	.sys_rst_i             (sys_rst_i),
	.track_enable_i        (track_enable_i),
	.ctl_o                 (ctl_o),
	.res_on_o              (res_on_o),
	.dev_dstate_o          (dev_dstate_o),
	.boot_start_o          (boot_start_o),
	.cold_boot_o           (cold_boot_o),
	.ended_state_o         (ended_state_o),
	.wake_status_flag_o    (wake_status_flag_o),
	.wake_result_status_o  (wake_result_status_o),
	.supply_state_result_o (supply_state_result_o)
);

// ==== tb/sss_sequencer_tb_top.sv ====
// Self-checking bench for the sleep-state sequencer.
// Assumes the checker is bound from its own file; the bench drives every input.
`timescale 1ns/1ns
module sss_sequencer_tb_top;
	import sss_pkg::*;
	logic sys_clk_i, sys_rst_i, primary_wr_i, secondary_wr_i, sleep_enable_bit_i;
	logic hibernate_req_i, wake_clear_i, power_fail_i, thermal_fail_i, track_enable_i;
	logic boot_start_o, cold_boot_o, wake_status_flag_o;
	logic [TYPE_W-1:0]  primary_type_i, secondary_type_i;
	logic [NUM_DEV-1:0] wake_event_i, wake_enable_i;
	logic [STATE_W-1:0] supply_state_i, ended_state_o, t;
	logic [NUM_RES-1:0] res_on_o;
	logic [WORD_W-1:0]  wake_result_status_o, supply_state_result_o;
	sss_level_t         res_level_i;
	sss_need_t          dev_need_i;
	sss_dstate_t        dev_req_dstate_i, dev_dstate_o;
	sss_ctl_s           ctl_o;
	int                 error_cnt, tests_run, seed;
	logic [2:0]         rp [4] = '{3'h3, 3'h1, 3'h6, 3'h3};
	logic [2:0]         rs [4] = '{3'h2, 3'h1, 3'h6, 3'h3};

	sss_sequencer u_dut (
		.sys_clk_i             (sys_clk_i),
		.sys_rst_i             (sys_rst_i),
		.primary_wr_i          (primary_wr_i),
		.primary_type_i        (primary_type_i),
		.secondary_wr_i        (secondary_wr_i),
		.secondary_type_i      (secondary_type_i),
		.sleep_enable_bit_i    (sleep_enable_bit_i),
		.hibernate_req_i       (hibernate_req_i),
		.wake_clear_i          (wake_clear_i),
		.wake_event_i          (wake_event_i),
		.wake_enable_i         (wake_enable_i),
		.power_fail_i          (power_fail_i),
		.thermal_fail_i        (thermal_fail_i),
		.supply_state_i        (supply_state_i),
		.track_enable_i        (track_enable_i),
		.res_level_i           (res_level_i),
		.dev_need_i            (dev_need_i),
		.dev_req_dstate_i      (dev_req_dstate_i),
		.ctl_o                 (ctl_o),
		.res_on_o              (res_on_o),
		.dev_dstate_o          (dev_dstate_o),
		.boot_start_o          (boot_start_o),
		.cold_boot_o           (cold_boot_o),
		.ended_state_o         (ended_state_o),
		.wake_status_flag_o    (wake_status_flag_o),
		.wake_result_status_o  (wake_result_status_o),
		.supply_state_result_o (supply_state_result_o)
	);

	initial begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	// ==========================================================
	// Helpers
	// Every step ends 1 ns after the edge, so design updates have landed.
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	function automatic logic [NUM_RES-1:0] exp_res(input logic [STATE_W-1:0] s);
		for (int i = 0; i < NUM_RES; i++)
			exp_res[i] = res_level_i[i] >= s;
	endfunction

	function automatic sss_dstate_t exp_dst(input logic [STATE_W-1:0] s);
		logic [NUM_RES-1:0] r;
		r = exp_res(s);
		for (int i = 0; i < NUM_DEV; i++)
			exp_dst[i] = (s >= ST_S4 || |(dev_need_i[i] & ~r)) ? DSTATE_D3 : dev_req_dstate_i[i];
	endfunction

	// Primary then secondary write on back-to-back edges, then settle.
	task automatic enter(input logic [TYPE_W-1:0] p, input logic [TYPE_W-1:0] s);
		primary_wr_i <= 1'b1;
		primary_type_i <= p;
		tick(1);
		primary_wr_i <= 1'b0;
		secondary_wr_i <= 1'b1;
		secondary_type_i <= s;
		tick(1);
		secondary_wr_i <= 1'b0;
		tick(3);
	endtask

	task automatic wake(input logic [STATE_W-1:0] s, input int dev);
		int n;
		n = 0;
		wake_event_i[dev] <= 1'b1;
		while (boot_start_o !== 1'b1 && n < 8) begin
			tick(1);
			n++;
		end
		if (boot_start_o !== 1'b1) begin
			error_cnt++;
			report_and_stop();
		end
		chk(wake_status_flag_o, 1);
		chk(ended_state_o, s);
		chk(cold_boot_o, s == ST_S5);
		wake_event_i <= '0;
		tick(2);
		chk(ctl_o, 3'h7);
		chk(dev_dstate_o, dev_req_dstate_i);
		wake_clear_i <= 1'b1;
		tick(1);
		wake_clear_i <= 1'b0;
		tick(1);
		chk(wake_status_flag_o, 0);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		seed = 31;
		{primary_wr_i, secondary_wr_i, hibernate_req_i, wake_clear_i, power_fail_i, thermal_fail_i} = '0;
		{primary_type_i, secondary_type_i, wake_event_i, supply_state_i} = '0;
		{res_level_i, dev_need_i, dev_req_dstate_i} = '0;
		{sleep_enable_bit_i, track_enable_i, sys_rst_i} = 3'h7;
		wake_enable_i = 4'he;
		tick(8);
		sys_rst_i <= 1'b0;
		tick(1);
		for (int k = 0; k < 4; k++) begin
			sleep_enable_bit_i <= k != 3;
			enter(rp[k], rs[k]);
			chk(ctl_o, 3'h7);
		end
		sleep_enable_bit_i <= 1'b1;
		for (int k = 0; k < 12; k++) begin
			t = ST_S2 + 3'(k % 4);
			for (int i = 0; i < NUM_RES; i++)
				res_level_i[i] <= 3'($unsigned($random(seed)) % 6);
			dev_need_i <= sss_need_t'($random(seed));
			dev_req_dstate_i <= sss_dstate_t'($random(seed));
			supply_state_i <= 3'($random(seed));
			wake_enable_i <= (t == ST_S5) ? 4'h0 : 4'he;
			enter(t, t);
			wake_enable_i <= 4'he;
			chk(ctl_o, t >= ST_S4 ? 3'h0 : 3'h1);
			chk(res_on_o, exp_res(t));
			chk(dev_dstate_o, exp_dst(t));
			chk(supply_state_result_o, supply_state_i);
			// The disabled source must not wake the system.
			wake_event_i[0] <= 1'b1;
			tick(5);
			chk(ctl_o, t >= ST_S4 ? 3'h0 : 3'h1);
			wake(t, 1 + k % 3);
		end
		for (int k = 0; k < 3; k++) begin
			enter(ST_S3, ST_S3);
			chk(wake_result_status_o, 0);
			{power_fail_i, thermal_fail_i, track_enable_i} <= {k == 0, k != 0, k != 2};
			tick(3);
			wake_event_i[1] <= 1'b1;
			tick(6);
			chk(ctl_o, 3'h1);
			chk(wake_result_status_o, k == 2 ? 0 : k + 1);
			{power_fail_i, thermal_fail_i, wake_event_i} <= '0;
			tick(3);
			wake(ST_S3, 2);
			track_enable_i <= 1'b1;
		end
		hibernate_req_i <= 1'b1;
		tick(1);
		hibernate_req_i <= 1'b0;
		tick(3);
		chk(ctl_o, 3'h0);
		chk(dev_dstate_o, {NUM_DEV{DSTATE_D3}});
		wake(ST_S4, 3);
		report_and_stop();
	end
endmodule
